/* File: src/ifb_flag_bank.sv */
// Purpose: Interrupt request flag bank with enables and one irq line
// Assumes: Event pulses come from logic on clk_sys
// Notes:   Registers reached over Avalon-MM with waitrequest
//
// Overview of operation
// - Flag reads one while its request pends
// - Unused bits ignore writes, read zero
// - All flags clear at reset
// - Software reads and writes every flag
// - Group1 high byte: uart2, irq2, timers, compares, dma2
// - Group1 low byte: captures, adc2, irq1, change, i2c1
// - Group2 high byte: timer6, dma4, compares 8-5, capture6
// - Group2 low byte: captures, dma3, can1, spi2
// - Group3 high byte: dma5, codec event/error, can2
// - Group3 low byte: can2 rx, irq4/3, timers, i2c2
// - Group0 bits: compare1, capture1, ext irq0
// - Matching enable bit lets flag request processor
`timescale 1ns/1ps
module ifb_flag_bank (
  input  wire logic                         clk_sys,
  input  wire logic                         sys_rst,
  input  wire ifb_pkg::ifb_evt_s            src_evt,
  input  wire logic [ifb_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [ifb_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [ifb_pkg::DATA_W-1:0]   avs_readdata,
  output logic                              avs_waitrequest,
  output logic                              irq
);

  localparam int NG = ifb_pkg::NGRP;

  logic [NG-1:0][15:0]        evt_v;
  logic [NG-1:0][15:0]        flag_ff;
  logic [NG-1:0][15:0]        nxt_flag;
  logic [NG-1:0][15:0]        en_ff;
  logic [NG-1:0][15:0]        nxt_en;
  ifb_pkg::ifb_bus_e          state_ff;
  ifb_pkg::ifb_bus_e          nxt_state;
  logic                       wait_ff;
  logic                       nxt_wait;
  logic [ifb_pkg::DATA_W-1:0] rdata_ff;
  logic [ifb_pkg::DATA_W-1:0] nxt_rdata;
  logic                       irq_ff;
  logic                       nxt_irq;
  logic                       req;
  logic                       wr_fire;
  logic                       hit_flg;
  logic                       hit_en;
  logic [1:0]                 idx;
  logic [15:0]                be16;
  logic [15:0]                wdat16;
  logic [ifb_pkg::DATA_W-1:0] rd_mux;
  logic                       any_pend;

  // Events arrive on named struct fields
  assign evt_v = src_evt;

  // Address decode
  assign req     = avs_read | avs_write;
  assign idx     = avs_address[3:2];
  assign hit_flg = (avs_address[5:4] == ifb_pkg::PAGE_FLG);
  assign hit_en  = (avs_address[5:4] == ifb_pkg::PAGE_EN);
  assign be16    = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdat16  = avs_writedata[15:0];
  assign wr_fire = (state_ff == ifb_pkg::ST_ACK) & avs_write;

  // Read multiplexer, unmapped words read zero
  always_comb begin
    rd_mux = ifb_pkg::RD_ZERO;
    if (hit_flg) begin
      rd_mux[15:0] = flag_ff[idx];
    end else if (hit_en) begin
      rd_mux[15:0] = en_ff[idx];
    end
  end

  // Bus handshake, one wait cycle per access
  always_comb begin
    nxt_state = state_ff;
    nxt_wait  = wait_ff;
    nxt_rdata = rdata_ff;
    case (state_ff)
      ifb_pkg::ST_IDLE: begin
        if (req) begin
          nxt_state = ifb_pkg::ST_ACK;
          nxt_wait  = 1'b0;
          nxt_rdata = avs_read ? rd_mux : ifb_pkg::RD_ZERO;
        end
      end
      ifb_pkg::ST_ACK: begin
        nxt_state = ifb_pkg::ST_IDLE;
        nxt_wait  = 1'b1;
      end
      default: begin
        nxt_state = ifb_pkg::ST_IDLE;
        nxt_wait  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ifb_pkg::ST_IDLE;
      wait_ff  <= 1'b1;
      rdata_ff <= ifb_pkg::RD_ZERO;
    end else begin
      state_ff <= nxt_state;
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // Per-group flag and enable update
  genvar g;
  generate
    for (g = 0; g < NG; g++) begin : gen_grp
      logic wsel_f;
      logic wsel_e;
      logic [15:0] base_f;
      logic [15:0] base_e;
      assign wsel_f = wr_fire & hit_flg & (idx == 2'(g));
      assign wsel_e = wr_fire & hit_en & (idx == 2'(g));
      assign base_f = wsel_f ?
        ((flag_ff[g] & ~be16) | (wdat16 & be16)) : flag_ff[g];
      assign base_e = wsel_e ?
        ((en_ff[g] & ~be16) | (wdat16 & be16)) : en_ff[g];
      // Event ORed after the write so a set beats a clear
      assign nxt_flag[g] =
        (base_f | evt_v[g]) & ifb_pkg::IMPL_MASK[g];
      assign nxt_en[g] = base_e & ifb_pkg::IMPL_MASK[g];
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NG; i++) begin
        flag_ff[i] <= ifb_pkg::FLG_RST;
        en_ff[i]   <= ifb_pkg::EN_RST;
      end
    end else begin
      flag_ff <= nxt_flag;
      en_ff   <= nxt_en;
    end
  end

  // Interrupt line, any enabled pending flag
  always_comb begin
    any_pend = |(flag_ff & en_ff);
    nxt_irq  = any_pend;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign irq             = irq_ff;

  // Checks
  logic [63:0] flag_flat;
  logic [63:0] evt_imp;
  logic [63:0] impl_flat;
  logic [15:0] wexp1;
  assign flag_flat = flag_ff;
  assign impl_flat = ifb_pkg::IMPL_MASK;
  assign evt_imp   = evt_v & ifb_pkg::IMPL_MASK;
  assign wexp1     = wdat16 & ifb_pkg::IMPL_MASK[1];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_req_idle;
    (state_ff == ifb_pkg::ST_IDLE) && req;
  endsequence

  sequence s_ack_then_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  sequence s_flag2_read;
    s_req_idle ##0 avs_read && hit_flg && (idx == 2'h2);
  endsequence

  unused_bits_zero_a: assert property (
    (flag_flat & ~impl_flat) == 64'h0000_0000_0000_0000
    && (en_ff & ~impl_flat) == 64'h0000_0000_0000_0000)
    else $error("unused flag or enable bit set");

  event_sets_a: assert property (
    (evt_imp != 64'h0000_0000_0000_0000)
    |=> ((flag_flat & $past(evt_imp)) == $past(evt_imp)))
    else $error("event did not set its flag");

  flag_hold_a: assert property (
    (!wr_fire && evt_imp == 64'h0000_0000_0000_0000)
    |=> $stable(flag_flat))
    else $error("flag changed without event or write");

  reset_clear_a: assert property (
    $past(sys_rst) |-> (flag_flat == 64'h0000_0000_0000_0000))
    else $error("flag not zero after reset");

  write_value_a: assert property (
    (wr_fire && hit_flg && idx == 2'h1 && (&avs_byteenable[1:0])
     && evt_v[1] == 16'h0000)
    |=> (flag_ff[1] == $past(wexp1)))
    else $error("flag write not stored");

  set_beats_clr_a: assert property (
    (wr_fire && hit_flg && idx == 2'h3 && evt_v[3][0])
    |=> flag_ff[3][0])
    else $error("clear won over event");

  read_back_a: assert property (
    s_flag2_read |=> !avs_waitrequest
    && avs_readdata == {16'h0000, $past(flag_ff[2])})
    else $error("flag read data wrong");

  bus_wait_a: assert property (
    s_req_idle |=> s_ack_then_wait)
    else $error("waitrequest sequence wrong");

  irq_level_a: assert property (
    ##1 (irq == $past(|(flag_ff & en_ff))))
    else $error("irq not following enabled flags");

  unmapped_write_a: assert property (
    (wr_fire && !hit_flg && !hit_en && evt_imp == 64'h0000_0000_0000_0000)
    |=> ($stable(flag_flat) && $stable(en_ff)))
    else $error("unmapped write changed a register");

  en_write_a: assert property (
    (wr_fire && hit_en && idx == 2'h2 && (&avs_byteenable[1:0]))
    |=> (en_ff[2] == ($past(wdat16) & ifb_pkg::IMPL_MASK[2])))
    else $error("enable write not stored");

  uart2_pos_a: assert property (
    src_evt.g1.uart2_tx_pending |=> flag_ff[1][15])
    else $error("uart2 tx flag misplaced");

  change_pos_a: assert property (
    src_evt.g1.pin_change_pending |=> flag_ff[1][3])
    else $error("change flag misplaced");

  timer6_pos_a: assert property (
    src_evt.g2.timer6_pending |=> flag_ff[2][15])
    else $error("timer6 flag misplaced");

  spi2_pos_a: assert property (
    src_evt.g2.spi2_error_pending |=> flag_ff[2][0])
    else $error("spi2 error flag misplaced");

  dma5_pos_a: assert property (
    src_evt.g3.dma_ch5_done_pending |=> flag_ff[3][13])
    else $error("dma5 flag misplaced");

  timer7_pos_a: assert property (
    src_evt.g3.timer7_pending |=> flag_ff[3][0])
    else $error("timer7 flag misplaced");

  compare1_pos_a: assert property (
    src_evt.g0.compare1_pending |=> flag_ff[0][2])
    else $error("compare1 flag misplaced");

  capture1_pos_a: assert property (
    src_evt.g0.capture1_pending |=> flag_ff[0][1])
    else $error("capture1 flag misplaced");

  ext_irq0_pos_a: assert property (
    src_evt.g0.ext_irq0_pending |=> flag_ff[0][0])
    else $error("ext irq0 flag misplaced");

  dma2_pos_a: assert property (
    src_evt.g1.dma_ch2_done_pending |=> flag_ff[1][8])
    else $error("dma2 flag misplaced");

  i2c1_pos_a: assert property (
    src_evt.g1.i2c1_slave_pending |=> flag_ff[1][0])
    else $error("i2c1 slave flag misplaced");

  capture6_pos_a: assert property (
    src_evt.g2.capture6_pending |=> flag_ff[2][8])
    else $error("capture6 flag misplaced");

  capture5_pos_a: assert property (
    src_evt.g2.capture5_pending |=> flag_ff[2][7])
    else $error("capture5 flag misplaced");

  can2_pos_a: assert property (
    src_evt.g3.can2_event_pending |=> flag_ff[3][8])
    else $error("can2 event flag misplaced");

  can2_rx_pos_a: assert property (
    src_evt.g3.can2_rx_ready_pending |=> flag_ff[3][7])
    else $error("can2 rx flag misplaced");

endmodule

/* File: src/ifb_pkg.sv */
// Purpose: Shared constants and types of the interrupt flag bank
// Assumes: Avalon-MM slave, 32-bit data, byte addresses
// Notes:   Four 16-bit flag groups with four matching enable registers
package ifb_pkg;
  localparam int          ADDR_W   = 6;
  localparam int          NGRP     = 4;
  localparam int          GRP_W    = 16;
  localparam int          DATA_W   = 32;
  localparam logic [1:0]  PAGE_FLG = 2'h0;
  localparam logic [1:0]  PAGE_EN  = 2'h1;
  localparam logic [15:0] FLG_RST  = 16'h0000;
  localparam logic [15:0] EN_RST   = 16'h0000;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
  // Implemented bits per group, unused bits stay zero
  localparam logic [NGRP-1:0][15:0] IMPL_MASK = {
    16'h39FF, 16'hDFFF, 16'hFFFB, 16'h0007};

  typedef struct packed {
    logic [15:3] outside;
    logic        compare1_pending;
    logic        capture1_pending;
    logic        ext_irq0_pending;
  } ifb_grp0_s;

  typedef struct packed {
    logic uart2_tx_pending;
    logic uart2_rx_pending;
    logic ext_irq2_pending;
    logic timer5_pending;
    logic timer4_pending;
    logic compare4_pending;
    logic compare3_pending;
    logic dma_ch2_done_pending;
    logic capture8_pending;
    logic capture7_pending;
    logic adc2_done_pending;
    logic ext_irq1_pending;
    logic pin_change_pending;
    logic unused2;
    logic i2c1_master_pending;
    logic i2c1_slave_pending;
  } ifb_grp1_s;

  typedef struct packed {
    logic timer6_pending;
    logic dma_ch4_done_pending;
    logic unused13;
    logic compare8_pending;
    logic compare7_pending;
    logic compare6_pending;
    logic compare5_pending;
    logic capture6_pending;
    logic capture5_pending;
    logic capture4_pending;
    logic capture3_pending;
    logic dma_ch3_done_pending;
    logic can1_event_pending;
    logic can1_rx_ready_pending;
    logic spi2_event_pending;
    logic spi2_error_pending;
  } ifb_grp2_s;

  typedef struct packed {
    logic [1:0] unused15_14;
    logic       dma_ch5_done_pending;
    logic       codec_if_event_pending;
    logic       codec_if_error_pending;
    logic [1:0] unused10_9;
    logic       can2_event_pending;
    logic       can2_rx_ready_pending;
    logic       ext_irq4_pending;
    logic       ext_irq3_pending;
    logic       timer9_pending;
    logic       timer8_pending;
    logic       i2c2_master_pending;
    logic       i2c2_slave_pending;
    logic       timer7_pending;
  } ifb_grp3_s;

  typedef struct packed {
    ifb_grp3_s g3;
    ifb_grp2_s g2;
    ifb_grp1_s g1;
    ifb_grp0_s g0;
  } ifb_evt_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } ifb_bus_e;
endpackage

/* File: test/ifb_src_model.sv */
// Purpose: Peripheral event sources facing the flag bank
// Assumes: Sources run on clk_sys
// Notes:   Each fire bit is registered into its event bit one cycle later
`timescale 1ns/1ps
module ifb_src_model (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic [63:0]        fire,
  output ifb_pkg::ifb_evt_s       src_evt
);
  // Pulse register, quiet during reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      src_evt <= '0;
    end else begin
      src_evt <= fire;
    end
  end
endmodule

/* File: test/ifb_flag_bank_tb_top.sv */
// Purpose: Self-checking bench of the interrupt flag bank
// Assumes: Bus tasks wait for waitrequest; clash test uses one wait
// Notes:   Reference model of flags and enables kept in one array, mreg
`timescale 1ns/1ps
module ifb_flag_bank_tb_top;
  logic                  clk_sys;
  logic                  sys_rst;
  logic [63:0]           fire;
  ifb_pkg::ifb_evt_s     src_evt;
  logic [5:0]            avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic [31:0]           avs_writedata;
  logic [3:0]            avs_byteenable;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic                  irq;
  logic [31:0]           rdata;
  logic [15:0]           mreg [8];
  int                    errors;
  int                    checked;
  int                    cyc;

  ifb_src_model u_ifb_src_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .fire(fire), .src_evt(src_evt));
  ifb_flag_bank u_ifb_flag_bank (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .src_evt(src_evt), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));

  always #5 clk_sys = ~clk_sys;

  task automatic results();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [5:0] a, input logic wr,
                     input logic [15:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Model write: unused bits stay zero, byte lanes honoured
  task automatic mwr(input int a, input logic [15:0] d, input logic [3:0] be);
    logic [15:0] bm;
    bm = {{8{be[1]}}, {8{be[0]}}};
    if (a < 32) begin
      mreg[a/4] = (mreg[a/4] & ~bm) | (d & bm & ifb_pkg::IMPL_MASK[a/4%4]);
    end
  endtask

  task automatic wr(input int a, input logic [15:0] d, input logic [3:0] be);
    bus(a[5:0], 1'b1, d, be);
    mwr(a, d, be);
  endtask

  task automatic rd_chk(input int a);
    bus(a[5:0], 1'b0, 16'h0000, 4'hF);
    chk(rdata, (a < 32) ? {16'h0000, mreg[a/4]} : 32'h0000_0000);
  endtask

  task automatic pulse(input logic [63:0] v);
    fire <= v;
    @(posedge clk_sys);
    fire <= '0;
    repeat (2) @(posedge clk_sys);
    for (int g = 0; g < 4; g++) begin
      mreg[g] = mreg[g] | (v[g*16 +: 16] & ifb_pkg::IMPL_MASK[g]);
    end
  endtask

  task automatic irq_chk();
    logic e;
    e = 1'b0;
    repeat (2) @(posedge clk_sys);
    for (int g = 0; g < 4; g++) begin
      e = e | (|(mreg[g] & mreg[g+4]));
    end
    chk({31'h0000_0000, irq}, {31'h0000_0000, e});
  endtask

  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    fire = '0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = '0;
    errors = 0;
    checked = 0;
    cyc = 0;
    foreach (mreg[i]) mreg[i] = 16'h0000;
    void'($urandom(73));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int a = 0; a < 40; a += 4) rd_chk(a);
    irq_chk();
    for (int a = 0; a < 40; a += 4) begin
      wr(a, 16'hFFFF, 4'h3);
      rd_chk(a);
      wr(a, 16'h0000, 4'h3);
    end
    // Each source reaches its own bit and no other bit of its group
    for (int i = 0; i < 64; i++) begin
      pulse(64'h1 << i);
      rd_chk(i / 16 * 4);
      wr(i / 16 * 4, 16'h0000, 4'h3);
    end
    // Event landing on the clearing write wins
    fire <= 64'h0001_0000_0000_0000;
    fork
      wr(12, 16'h0000, 4'h3);
      begin
        @(posedge clk_sys);
        fire <= '0;
      end
    join
    mreg[3] = 16'h0001;
    rd_chk(12);
    wr(12, 16'h0000, 4'h3);
    // Random mix of events, writes and reads
    for (int n = 0; n < 300; n++) begin
      case ($urandom % 3)
        0: pulse({$urandom, $urandom});
        1: wr(($urandom % 8) * 4, 16'($urandom), 4'($urandom));
        default: rd_chk(($urandom % 10) * 4);
      endcase
      irq_chk();
    end
    // Reset in mid-run clears set flags and enables
    pulse('1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    foreach (mreg[i]) mreg[i] = 16'h0000;
    for (int a = 0; a < 32; a += 4) rd_chk(a);
    irq_chk();
    results();
  end
endmodule
